// [include/pump_status_pkg.sv]
package pump_status_pkg;

   // ****************************************
   // register numbers on the RS pins
   // ****************************************
   localparam logic [2:0] ADDR_PARALLEL_DATA = 3'h3;
   localparam logic [2:0] ADDR_RAM_CTRL = 3'h4;
   localparam logic [2:0] ADDR_PUMP_STATUS = 3'h5;
   localparam logic [2:0] ADDR_FRAME_STATUS = 3'h7;

   // ****************************************
   // control register field positions
   // ****************************************
   localparam int RAM_LOW_LSB = 0;
   localparam int RAM_LOW_MSB = 2;
   localparam int BIT_REG_RTS = 3;
   localparam int BIT_PAR_MODE = 4;
   localparam int BIT_RAM_DONE_IE = 5;
   localparam int BIT_RX_READY_IE = 6;
   localparam int BIT_TX_READY_IE = 7;

   // ****************************************
   // status register field positions
   // ****************************************
   localparam int BIT_RESET_PROG = 0;
   localparam int BIT_CARRIER = 1;
   localparam int BIT_RETRAIN = 2;
   localparam int BIT_RESERVED = 3;
   localparam int BIT_TX_BUSY = 4;
   localparam int BIT_RAM_DONE = 5;
   localparam int BIT_RX_READY = 6;
   localparam int BIT_TX_READY = 7;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RAM_CTRL_RESET = 8'h00;
   localparam logic [7:0] PUMP_STATUS_RESET = 8'h40;
   localparam logic [7:0] OCTET_RESET = 8'h00;
   // arbitrary value, stands in for the firmware version
   localparam logic [7:0] FW_VERSION = 8'h5A;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic rd_pulse;
      logic wr_pulse;
      logic rd_active;
   } bus_req_t;

   typedef struct packed {
      logic reset_done;
      logic data_mode_ready;
      logic retrain_active;
      logic no_signal;
      logic mode_2400;
      logic retrain_req;
      logic tx_start;
      logic tx_buf_empty;
      logic dialing;
      logic standby_write;
      logic ram_done;
      logic rx_valid;
      logic [7:0] rx_octet;
      logic tx_take;
   } pump_evt_t;

endpackage : pump_status_pkg

// [rtl/host_strobe_sync.sv]
`timescale 1ns/1ps
module host_strobe_sync
   import pump_status_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [2:0] rs,
   input wire logic [7:0] data_i,
   output bus_req_t req
);

   // ****************************************
   // two-flop synchroniser on every bus pin
   // ****************************************
   localparam int PW = 14;
   logic [PW-1:0] meta_r;
   logic [PW-1:0] sync_r;
   logic rd_last_r;
   logic wr_last_r;
   logic sel;
   logic rd_n_s;
   logic wr_n_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= {PW{1'b1}};
         sync_r <= {PW{1'b1}};
      end else begin
         meta_r <= {cs_n, rd_n, wr_n, rs, data_i};
         sync_r <= meta_r;
      end
   end

   assign sel = ~sync_r[13];
   assign rd_n_s = sync_r[12];
   assign wr_n_s = sync_r[11];

   // edges seen only on the settled copy
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_last_r <= 1'b1;
         wr_last_r <= 1'b1;
      end else begin
         rd_last_r <= rd_n_s;
         wr_last_r <= wr_n_s;
      end
   end

   // write taken at the rising edge, where host data is stable
   always_comb begin
      req.addr = sync_r[10:8];
      req.wdata = sync_r[7:0];
      req.rd_pulse = sel & rd_last_r & ~rd_n_s;
      req.wr_pulse = sel & ~wr_last_r & wr_n_s;
      req.rd_active = sel & ~rd_n_s;
   end

endmodule : host_strobe_sync

// [rtl/modem_host_status_irq.sv]
`timescale 1ns/1ps
module modem_host_status_irq
   import pump_status_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [2:0] RS,
   input wire logic [7:0] DATA_I,
   output logic [7:0] DATA_O,
   output logic DATA_OE,
   input wire logic RTS_PIN,
   input wire pump_evt_t PUMP_EVT,
   output logic HOST_IRQ_OUT,
   output logic LINE_SIGNAL_DETECT_N,
   output logic RTS_EFFECTIVE,
   output logic PARALLEL_MODE_SELECT,
   output logic [2:0] RAM_CTRL_LOW,
   output logic [7:0] TX_OCTET,
   output logic TX_OCTET_LOADED
);

   // ****************************************
   // host bus front end
   // ****************************************
   bus_req_t req;

   host_strobe_sync u_sync (
      .clk(REF_CLK),
      .rst(RST),
      .cs_n(CS_N),
      .rd_n(RD_N),
      .wr_n(WR_N),
      .rs(RS),
      .data_i(DATA_I),
      .req(req)
   );

   function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] want);
      hit = strobe & (a == want);
   endfunction : hit

   logic wr_ctrl;
   logic wr_par;
   logic rd_par;
   logic rd_stat;
   assign wr_ctrl = hit(req.wr_pulse, req.addr, ADDR_RAM_CTRL);
   assign wr_par = hit(req.wr_pulse, req.addr, ADDR_PARALLEL_DATA);
   assign rd_par = hit(req.rd_pulse, req.addr, ADDR_PARALLEL_DATA);
   assign rd_stat = hit(req.rd_pulse, req.addr, ADDR_PUMP_STATUS);

   // ****************************************
   // rts pin synchroniser
   // ****************************************
   logic rts_meta_r;
   logic rts_sync_r;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rts_meta_r <= 1'b0;
         rts_sync_r <= 1'b0;
      end else begin
         rts_meta_r <= RTS_PIN;
         rts_sync_r <= rts_meta_r;
      end
   end

   // ****************************************
   // control register
   // ****************************************
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = req.wdata;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ctrl_r <= RAM_CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   logic par_mode;
   logic reg_request_to_send;
   assign par_mode = ctrl_r[BIT_PAR_MODE];
   assign reg_request_to_send = ctrl_r[BIT_REG_RTS];

   // ****************************************
   // reset in progress
   // ****************************************
   logic reset_in_progress_r;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         reset_in_progress_r <= 1'b1;
      end else if (PUMP_EVT.reset_done) begin
         reset_in_progress_r <= 1'b0;
      end
   end

   // ****************************************
   // carrier present
   // ****************************************
   logic carrier_present_r;
   logic carrier_nxt;

   // a fresh entry into data mode outranks any clear in the same cycle
   always_comb begin
      carrier_nxt = carrier_present_r;
      if (PUMP_EVT.data_mode_ready) begin
         carrier_nxt = 1'b1;
      end else if (PUMP_EVT.retrain_active | PUMP_EVT.no_signal) begin
         carrier_nxt = 1'b0;
      end else if (PUMP_EVT.standby_write) begin
         carrier_nxt = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         carrier_present_r <= 1'b0;
      end else begin
         carrier_present_r <= carrier_nxt;
      end
   end

   // ****************************************
   // retrain seen
   // ****************************************
   logic retrain_seen_r;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         retrain_seen_r <= 1'b0;
      end else if (PUMP_EVT.retrain_req & PUMP_EVT.mode_2400) begin
         retrain_seen_r <= 1'b1;
      end else if (PUMP_EVT.standby_write) begin
         retrain_seen_r <= 1'b0;
      end
   end

   // ****************************************
   // transmitter busy
   // ****************************************
   logic transmitter_busy_r;
   logic busy_nxt;

   // meaningless in framed mode; the pump side must not rely on it there
   always_comb begin
      busy_nxt = transmitter_busy_r;
      if (PUMP_EVT.dialing) begin
         busy_nxt = 1'b1;
      end else if (PUMP_EVT.tx_start & reg_request_to_send) begin
         busy_nxt = 1'b1;
      end else if (PUMP_EVT.standby_write) begin
         busy_nxt = 1'b0;
      end else if (~reg_request_to_send & PUMP_EVT.tx_buf_empty) begin
         busy_nxt = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         transmitter_busy_r <= 1'b0;
      end else begin
         transmitter_busy_r <= busy_nxt;
      end
   end

   // ****************************************
   // event flags, set beats clear
   // ****************************************
   logic ram_done_flag_r;
   logic rx_ready_flag_r;
   logic tx_ready_flag_r;
   logic ram_done_nxt;
   logic rx_ready_nxt;
   logic tx_ready_nxt;

   always_comb begin
      ram_done_nxt = ram_done_flag_r;
      if (PUMP_EVT.ram_done) begin
         ram_done_nxt = 1'b1;
      end else if (rd_stat) begin
         ram_done_nxt = 1'b0;
      end
   end

   always_comb begin
      rx_ready_nxt = rx_ready_flag_r;
      if (PUMP_EVT.rx_valid & par_mode) begin
         rx_ready_nxt = 1'b1;
      end else if (rd_par) begin
         rx_ready_nxt = 1'b0;
      end
   end

   always_comb begin
      tx_ready_nxt = tx_ready_flag_r;
      if (PUMP_EVT.tx_take & par_mode) begin
         tx_ready_nxt = 1'b1;
      end else if (wr_par) begin
         tx_ready_nxt = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ram_done_flag_r <= PUMP_STATUS_RESET[BIT_RAM_DONE];
         rx_ready_flag_r <= PUMP_STATUS_RESET[BIT_RX_READY];
         tx_ready_flag_r <= PUMP_STATUS_RESET[BIT_TX_READY];
      end else begin
         ram_done_flag_r <= ram_done_nxt;
         rx_ready_flag_r <= rx_ready_nxt;
         tx_ready_flag_r <= tx_ready_nxt;
      end
   end

   // ****************************************
   // parallel data octets
   // ****************************************
   logic [7:0] rx_octet_r;
   logic [7:0] tx_octet_r;
   logic tx_loaded_r;

   // version shown after reset and standby until the first received octet
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rx_octet_r <= FW_VERSION;
      end else if (PUMP_EVT.rx_valid & par_mode) begin
         rx_octet_r <= PUMP_EVT.rx_octet;
      end else if (PUMP_EVT.standby_write) begin
         rx_octet_r <= FW_VERSION;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tx_octet_r <= OCTET_RESET;
         tx_loaded_r <= 1'b0;
      end else begin
         tx_loaded_r <= wr_par;
         if (wr_par) begin
            tx_octet_r <= req.wdata;
         end
      end
   end

   // ****************************************
   // status word and read mux
   // ****************************************
   logic [7:0] status_word;
   logic [7:0] rd_word;

   always_comb begin
      status_word = READ_ZERO;
      status_word[BIT_RESET_PROG] = reset_in_progress_r;
      status_word[BIT_CARRIER] = carrier_present_r;
      status_word[BIT_RETRAIN] = retrain_seen_r;
      status_word[BIT_RESERVED] = 1'b0;
      status_word[BIT_TX_BUSY] = transmitter_busy_r;
      status_word[BIT_RAM_DONE] = ram_done_flag_r;
      status_word[BIT_RX_READY] = rx_ready_flag_r;
      status_word[BIT_TX_READY] = tx_ready_flag_r;
   end

   // status has no write path at all, so host writes there fall away
   always_comb begin
      unique case (req.addr)
         ADDR_PARALLEL_DATA: rd_word = rx_octet_r;
         ADDR_RAM_CTRL: rd_word = ctrl_r;
         ADDR_PUMP_STATUS: rd_word = status_word;
         default: rd_word = READ_ZERO;
      endcase
   end

   logic [7:0] data_o_r;
   logic data_oe_r;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         data_o_r <= READ_ZERO;
         data_oe_r <= 1'b0;
      end else begin
         data_oe_r <= req.rd_active;
         if (req.rd_pulse) begin
            data_o_r <= rd_word;
         end
      end
   end

   // ****************************************
   // pins toward host and pump
   // ****************************************
   logic host_irq_r;
   logic lsd_n_r;
   logic rts_eff_r;

   // built from next values so pins track the flags without lag
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         host_irq_r <= 1'b0;
         lsd_n_r <= 1'b1;
         rts_eff_r <= 1'b0;
      end else begin
         host_irq_r <= (ram_done_nxt & ctrl_nxt[BIT_RAM_DONE_IE])
            | (rx_ready_nxt & ctrl_nxt[BIT_RX_READY_IE])
            | (tx_ready_nxt & ctrl_nxt[BIT_TX_READY_IE]);
         lsd_n_r <= ~carrier_nxt;
         rts_eff_r <= ctrl_nxt[BIT_REG_RTS] | rts_sync_r;
      end
   end

   assign DATA_O = data_o_r;
   assign DATA_OE = data_oe_r;
   assign HOST_IRQ_OUT = host_irq_r;
   assign LINE_SIGNAL_DETECT_N = lsd_n_r;
   assign RTS_EFFECTIVE = rts_eff_r;
   assign PARALLEL_MODE_SELECT = ctrl_r[BIT_PAR_MODE];
   assign RAM_CTRL_LOW = ctrl_r[RAM_LOW_MSB:RAM_LOW_LSB];
   assign TX_OCTET = tx_octet_r;
   assign TX_OCTET_LOADED = tx_loaded_r;

endmodule : modem_host_status_irq

// [sim/host.sv]
`timescale 1ns/1ps
module host
   import pump_status_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] dout,
   input wire logic oe,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [2:0] rs,
   output logic [7:0] din
);
   // ********
   // host bus cycles
   // ********
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      rs = 3'h0;
      din = 8'h00;
   end
   // pins are synchronised, so every phase is held four clocks
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      rs = a;
      din = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (4) @(negedge clk);
      wr_n = 1'b1;
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      din = ~d;
      repeat (4) @(negedge clk);
   endtask : wr
   task rd(input logic [2:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      rs = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (oe !== 1'b1 && n < 20);
      d = (oe === 1'b1) ? dout : 8'hXX;
      @(negedge clk);
      rd_n = 1'b1;
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask : rd
   // polls busy before standby may be issued
   task idle(output logic [7:0] d);
      int n;
      n = 0;
      do begin
         rd(ADDR_PUMP_STATUS, d);
         n++;
      end while (d[BIT_TX_BUSY] !== 1'b0 && n < 20);
   endtask : idle
endmodule : host

// [sim/status_checker.sv]
`timescale 1ns/1ps
module status_checker
   import pump_status_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic RTS_PIN,
   input wire pump_evt_t PUMP_EVT,
   input wire logic DATA_OE,
   input wire logic HOST_IRQ_OUT,
   input wire logic LINE_SIGNAL_DETECT_N,
   input wire logic RTS_EFFECTIVE,
   input wire logic PARALLEL_MODE_SELECT,
   input wire logic [7:0] TX_OCTET,
   input wire logic TX_OCTET_LOADED
);
   // ********
   // port relations
   // ********
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_reset_quiet: assert property (disable iff (1'b0) RST |=>
      !HOST_IRQ_OUT && LINE_SIGNAL_DETECT_N && !DATA_OE && !RTS_EFFECTIVE)
      else $error("outputs active after reset");
   a_carrier_on: assert property (PUMP_EVT.data_mode_ready |=>
      !LINE_SIGNAL_DETECT_N) else $error("detect pin not low");
   a_carrier_lost: assert property ((PUMP_EVT.no_signal ||
      PUMP_EVT.retrain_active) && !PUMP_EVT.data_mode_ready |=> LINE_SIGNAL_DETECT_N)
      else $error("detect pin not high");
   a_standby_drop: assert property (PUMP_EVT.standby_write &&
      !PUMP_EVT.data_mode_ready |=> LINE_SIGNAL_DETECT_N) else $error("carrier kept");
   a_rts_pin: assert property (RTS_PIN [*4] |=> RTS_EFFECTIVE)
      else $error("pin rts ignored");
   a_oe_cause: assert property ($rose(DATA_OE) |->
      $past(RD_N, 2) == 1'b0 && $past(CS_N, 2) == 1'b0) else $error("bus driven unasked");
   a_oe_release: assert property (RD_N [*4] |=> !DATA_OE)
      else $error("bus held after read");
   a_mode_write: assert property ($changed(PARALLEL_MODE_SELECT) |->
      $past(CS_N, 3) == 1'b0) else $error("mode changed without write");
   a_octet_load: assert property ($changed(TX_OCTET) |-> TX_OCTET_LOADED)
      else $error("octet changed without pulse");
   a_load_pulse: assert property (TX_OCTET_LOADED |=> !TX_OCTET_LOADED)
      else $error("load pulse too long");
   c_irq: cover property ($rose(HOST_IRQ_OUT));
   c_carrier: cover property ($fell(LINE_SIGNAL_DETECT_N));
   c_load: cover property (TX_OCTET_LOADED);
endmodule : status_checker

bind modem_host_status_irq status_checker i_status_checker (
   .REF_CLK(REF_CLK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N), .RTS_PIN(RTS_PIN),
   .PUMP_EVT(PUMP_EVT), .DATA_OE(DATA_OE), .HOST_IRQ_OUT(HOST_IRQ_OUT),
   .LINE_SIGNAL_DETECT_N(LINE_SIGNAL_DETECT_N), .RTS_EFFECTIVE(RTS_EFFECTIVE),
   .PARALLEL_MODE_SELECT(PARALLEL_MODE_SELECT), .TX_OCTET(TX_OCTET),
   .TX_OCTET_LOADED(TX_OCTET_LOADED)
);

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
   import pump_status_pkg::*;
   logic clk, rst, rts_pin, cs_n, rd_n, wr_n, oe, irq, lsd_n, rts_eff, par, tx_ld;
   logic [2:0] rs, ram_low;
   logic [7:0] din, dout, tx_oct, v;
   pump_evt_t evt;
   int error_cnt = 0;
   int total_checks = 0;
   int eb[3] = '{10, 9, 0};
   int cb[3] = '{18, 17, 11};
   // ********
   // harness
   // ********
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   modem_host_status_irq i_modem_host_status_irq (
      .REF_CLK(clk), .RST(rst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .RS(rs),
      .DATA_I(din), .DATA_O(dout), .DATA_OE(oe), .RTS_PIN(rts_pin), .PUMP_EVT(evt),
      .HOST_IRQ_OUT(irq), .LINE_SIGNAL_DETECT_N(lsd_n), .RTS_EFFECTIVE(rts_eff),
      .PARALLEL_MODE_SELECT(par), .RAM_CTRL_LOW(ram_low), .TX_OCTET(tx_oct),
      .TX_OCTET_LOADED(tx_ld)
   );
   host i_host (.clk(clk), .dout(dout), .oe(oe), .cs_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .rs(rs), .din(din));
   task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s exp %h seen %h", n, exp, seen);
      end
   endtask : chk
   task pulse(input int b);
      evt[b] = 1'b1;
      @(negedge clk);
      evt[b] = 1'b0;
   endtask : pulse
   task test_done;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   // run takes about four hundred clocks, so ten thousand clocks is a hang
   initial begin
      #400000;
      error_cnt++;
      test_done;
   end
   // ********
   // tests
   // ********
   initial begin
      rst = 1'b1;
      rts_pin = 1'b0;
      evt = '0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      i_host.rd(3'h4, v); chk("ctrl", v, 8'h00);
      i_host.rd(3'h5, v); chk("status", v, 8'h41);
      pulse(20);
      i_host.rd(3'h5, v); chk("status", v, 8'h40);
      i_host.wr(3'h5, 8'hFF);
      i_host.rd(3'h5, v); chk("status ro", v, 8'h40);
      i_host.rd(3'h6, v); chk("unmapped", v, 8'h00);
      chk("detect", {7'h0, lsd_n}, 8'h01);
      $display("test reset done");
      i_host.wr(3'h4, 8'h50);
      chk("par", {7'h0, par}, 8'h01);
      chk("irq", {7'h0, irq}, 8'h01);
      i_host.rd(3'h3, v); chk("octet", v, FW_VERSION);
      chk("irq", {7'h0, irq}, 8'h00);
      evt.rx_octet = 8'hA5;
      for (int k = 0; k < 3; k++) begin
         i_host.wr(3'h4, 8'h10 | (8'h20 << k));
         pulse(eb[k]);
         chk("irq", {7'h0, irq}, 8'h01);
         i_host.rd(3'h5, v); chk("flag", v, 8'h20 << k);
         if (k == 1) begin
            i_host.rd(3'h3, v); chk("octet", v, 8'hA5);
         end
         if (k == 2) begin
            i_host.wr(3'h3, 8'h3C);
            chk("tx octet", tx_oct, 8'h3C);
            chk("loaded", {7'h0, tx_ld}, 8'h00);
         end
         chk("irq", {7'h0, irq}, 8'h00);
      end
      i_host.wr(3'h4, 8'hE0);
      chk("par", {7'h0, par}, 8'h00);
      pulse(9);
      pulse(0);
      chk("irq", {7'h0, irq}, 8'h00);
      i_host.rd(3'h5, v); chk("serial", v & 8'hC0, 8'h00);
      $display("test interrupts done");
      foreach (cb[k]) begin
         pulse(19);
         chk("detect", {7'h0, lsd_n}, 8'h00);
         i_host.rd(3'h5, v); chk("carrier", v & 8'h02, 8'h02);
         pulse(cb[k]);
         chk("detect", {7'h0, lsd_n}, 8'h01);
      end
      pulse(15);
      i_host.rd(3'h5, v); chk("retrain", v & 8'h04, 8'h00);
      evt.mode_2400 = 1'b1;
      pulse(15);
      i_host.rd(3'h5, v); chk("retrain", v & 8'h04, 8'h04);
      $display("test carrier done");
      i_host.wr(3'h4, 8'h08);
      chk("rts", {7'h0, rts_eff}, 8'h01);
      pulse(14);
      i_host.rd(3'h5, v); chk("busy", v & 8'h10, 8'h10);
      pulse(11);
      i_host.rd(3'h5, v); chk("busy", v & 8'h10, 8'h00);
      pulse(14);
      i_host.wr(3'h4, 8'h00);
      i_host.rd(3'h5, v); chk("busy", v & 8'h10, 8'h10);
      evt.tx_buf_empty = 1'b1;
      i_host.idle(v); chk("busy", v & 8'h10, 8'h00);
      evt.dialing = 1'b1;
      i_host.rd(3'h5, v); chk("busy", v & 8'h10, 8'h10);
      evt.dialing = 1'b0;
      rts_pin = 1'b1;
      repeat (5) @(negedge clk);
      chk("rts", {7'h0, rts_eff}, 8'h01);
      rts_pin = 1'b0;
      repeat (5) @(negedge clk);
      chk("rts", {7'h0, rts_eff}, 8'h00);
      $display("test busy done");
      i_host.wr(3'h4, 8'hFF);
      i_host.rd(3'h4, v); chk("ctrl", v, 8'hFF);
      chk("ram low", {5'h0, ram_low}, 8'h07);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      i_host.rd(3'h4, v); chk("ctrl", v, 8'h00);
      i_host.rd(3'h5, v); chk("status", v, 8'h41);
      chk("ram low", {5'h0, ram_low}, 8'h00);
      $display("test rereset done");
      test_done;
   end
endmodule : tb
